// >>> rtl/bcc_top.v
// Channel C address and data match block with its Avalon-MM registers.
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "bcc_map.vh"

module bcc_top (
	// Clock and power-on reset.
	input  wire                 MCLK,
	input  wire                 RESET_N,
	// Avalon-MM slave.
	input  wire [`BCC_AW-1:0]   ADDRESS,
	input  wire                 READ,
	input  wire                 WRITE,
	input  wire [3:0]           BYTEENABLE,
	input  wire [`BCC_DW-1:0]   WRITEDATA,
	output reg  [`BCC_DW-1:0]   READDATA,
	output reg                  WAITREQUEST,
	// Internal buses, same clock.
	input  wire                 CYCLE_VALID,
	input  wire [`BCC_WW-1:0]   INT_ADDR,
	input  wire [`BCC_WW-1:0]   INT_DATA,
	// X and Y memory buses, same clock.
	input  wire [`BCC_HW-1:0]   X_MEM_ADDR_BUS,
	input  wire [`BCC_HW-1:0]   Y_MEM_ADDR_BUS,
	input  wire [`BCC_HW-1:0]   X_MEM_DATA_BUS,
	input  wire [`BCC_HW-1:0]   Y_MEM_DATA_BUS,
	// Match results.
	output reg                  ADDR_MATCH,
	output reg                  DATA_MATCH
);

	// Programmed registers.
	reg  [`BCC_HW-1:0]  chan_c_compare_addr_high_reg;
	reg  [`BCC_HW-1:0]  chan_c_compare_addr_low_reg;
	reg  [`BCC_HW-1:0]  chan_c_addr_mask_high_reg;
	reg  [`BCC_HW-1:0]  chan_c_addr_mask_low_reg;
	reg  [`BCC_HW-1:0]  chan_c_compare_data_high_reg;
	reg  [`BCC_HW-1:0]  chan_c_compare_data_low_reg;
	reg                 xy_bus_enable_select_reg;
	reg                 x_or_y_selector_reg;
	// Sticky hit flags.
	reg                 addr_hit_reg;
	reg                 data_hit_reg;
	reg                 addr_hit_next;
	reg                 data_hit_next;
	// Bus handshake.
	reg                 wait_next;
	reg  [`BCC_DW-1:0]  rdata_next;
	wire                req;
	wire                wr_go;
	wire [`BCC_NREG-1:0] sel;
	// Comparator plumbing.
	wire [`BCC_WW-1:0]  chan_c_compare_addr;
	wire [`BCC_WW-1:0]  chan_c_addr_mask;
	wire [`BCC_WW-1:0]  chan_c_compare_data;
	wire [`BCC_WW-1:0]  a_bus;
	wire [`BCC_WW-1:0]  a_ref;
	wire [`BCC_WW-1:0]  a_care;
	wire [`BCC_WW-1:0]  d_bus;
	wire [`BCC_WW-1:0]  d_ref;
	wire [`BCC_WW-1:0]  d_care;
	wire                a_eq;
	wire                d_eq;
	wire                a_hit;
	wire                d_hit;

	// One-hot decode of a byte address; shared by the read and write paths.
	function [`BCC_NREG-1:0] reg_sel;
		input [`BCC_AW-1:0] adr;
		begin
			reg_sel = {`BCC_NREG{1'b0}};
			case (adr)
				`BCC_OFS_AH:   reg_sel[0] = 1'b1;
				`BCC_OFS_AL:   reg_sel[1] = 1'b1;
				`BCC_OFS_MH:   reg_sel[2] = 1'b1;
				`BCC_OFS_ML:   reg_sel[3] = 1'b1;
				`BCC_OFS_DH:   reg_sel[4] = 1'b1;
				`BCC_OFS_DL:   reg_sel[5] = 1'b1;
				`BCC_OFS_SEL:  reg_sel[6] = 1'b1;
				`BCC_OFS_STAT: reg_sel[7] = 1'b1;
				default:       reg_sel = {`BCC_NREG{1'b0}};
			endcase
		end
	endfunction

	// Byte-lane merge of a 16-bit half held in the low lanes.
	function [`BCC_HW-1:0] lane_merge;
		input [`BCC_HW-1:0] old_v;
		input [`BCC_HW-1:0] new_v;
		input [1:0]         be;
		begin
			lane_merge = old_v;
			if (be[0])
				lane_merge[7:0] = new_v[7:0];
			if (be[1])
				lane_merge[15:8] = new_v[15:8];
		end
	endfunction

	// Request decode. Read and write never come together.
	// A write lands at the edge where waitrequest is seen low, never earlier.
	assign req   = READ | WRITE;
	assign wr_go = WRITE & ~WAITREQUEST;
	assign sel   = reg_sel(ADDRESS);

	// Every access waits exactly one cycle; the data is ready at the second edge.
	always @* begin
		wait_next = 1'b1;
		if (req && WAITREQUEST)
			wait_next = 1'b0;
	end

	// Read multiplexer; unmapped addresses read as zero.
	// Status and select words sit in the low byte lanes; upper lanes read zero.
	always @* begin
		rdata_next = `BCC_RST_WORD;
		case (1'b1)
			sel[0]: rdata_next[`BCC_HW-1:0] = chan_c_compare_addr_high_reg;
			sel[1]: rdata_next[`BCC_HW-1:0] = chan_c_compare_addr_low_reg;
			sel[2]: rdata_next[`BCC_HW-1:0] = chan_c_addr_mask_high_reg;
			sel[3]: rdata_next[`BCC_HW-1:0] = chan_c_addr_mask_low_reg;
			sel[4]: rdata_next[`BCC_HW-1:0] = chan_c_compare_data_high_reg;
			sel[5]: rdata_next[`BCC_HW-1:0] = chan_c_compare_data_low_reg;
			sel[6]: begin
				rdata_next[`BCC_SEL_XYEN] = xy_bus_enable_select_reg;
				rdata_next[`BCC_SEL_XSY]  = x_or_y_selector_reg;
			end
			sel[7]: begin
				rdata_next[`BCC_ST_ALIVE] = ADDR_MATCH;
				rdata_next[`BCC_ST_DLIVE] = DATA_MATCH;
				rdata_next[`BCC_ST_AHIT]  = addr_hit_reg;
				rdata_next[`BCC_ST_DHIT]  = data_hit_reg;
			end
			default: rdata_next = `BCC_RST_WORD;
		endcase
	end

	// Handshake flops. Waitrequest idles high so no access slips through unseen.
	// The fixed single wait state costs a cycle per access but keeps the read
	// multiplexer off the path from the address pins to the data output.
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			WAITREQUEST <= 1'b1;
			READDATA    <= `BCC_RST_WORD;
		end else begin
			WAITREQUEST <= wait_next;
			if (READ && WAITREQUEST)
				READDATA <= rdata_next;
		end
	end

	// Upper compare address half. Only power-on reset touches it; a manual
	// reset is not a port here, so the value simply survives it.
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			chan_c_compare_addr_high_reg <= `BCC_RST_HALF;
		end else if (wr_go && sel[0]) begin
			chan_c_compare_addr_high_reg <= lane_merge(
				chan_c_compare_addr_high_reg,
				WRITEDATA[`BCC_HW-1:0], BYTEENABLE[1:0]);
		end
	end

	// Lower compare address half.
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			chan_c_compare_addr_low_reg <= `BCC_RST_HALF;
		end else if (wr_go && sel[1]) begin
			chan_c_compare_addr_low_reg <= lane_merge(
				chan_c_compare_addr_low_reg,
				WRITEDATA[`BCC_HW-1:0], BYTEENABLE[1:0]);
		end
	end

	// Upper address mask half; clear means every bit counts.
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			chan_c_addr_mask_high_reg <= `BCC_RST_HALF;
		end else if (wr_go && sel[2]) begin
			chan_c_addr_mask_high_reg <= lane_merge(
				chan_c_addr_mask_high_reg,
				WRITEDATA[`BCC_HW-1:0], BYTEENABLE[1:0]);
		end
	end

	// Lower address mask half.
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			chan_c_addr_mask_low_reg <= `BCC_RST_HALF;
		end else if (wr_go && sel[3]) begin
			chan_c_addr_mask_low_reg <= lane_merge(
				chan_c_addr_mask_low_reg,
				WRITEDATA[`BCC_HW-1:0], BYTEENABLE[1:0]);
		end
	end

	// Upper compare data half.
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			chan_c_compare_data_high_reg <= `BCC_RST_HALF;
		end else if (wr_go && sel[4]) begin
			chan_c_compare_data_high_reg <= lane_merge(
				chan_c_compare_data_high_reg,
				WRITEDATA[`BCC_HW-1:0], BYTEENABLE[1:0]);
		end
	end

	// Lower compare data half.
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			chan_c_compare_data_low_reg <= `BCC_RST_HALF;
		end else if (wr_go && sel[5]) begin
			chan_c_compare_data_low_reg <= lane_merge(
				chan_c_compare_data_low_reg,
				WRITEDATA[`BCC_HW-1:0], BYTEENABLE[1:0]);
		end
	end

	// Bus selection bits; both sit in byte lane 1.
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			xy_bus_enable_select_reg <= `BCC_RST_BIT;
			x_or_y_selector_reg      <= `BCC_RST_BIT;
		end else if (wr_go && sel[6] && BYTEENABLE[1]) begin
			xy_bus_enable_select_reg <= WRITEDATA[`BCC_SEL_XYEN];
			x_or_y_selector_reg      <= WRITEDATA[`BCC_SEL_XSY];
		end
	end

	// Whole 32-bit views of the paired halves.
	// Keeping the halves as separate flops lets each be written on its own.
	assign chan_c_compare_addr = {chan_c_compare_addr_high_reg,
		chan_c_compare_addr_low_reg};
	assign chan_c_addr_mask = {chan_c_addr_mask_high_reg,
		chan_c_addr_mask_low_reg};
	assign chan_c_compare_data = {chan_c_compare_data_high_reg,
		chan_c_compare_data_low_reg};

	// Address lane: internal bus, or X on the upper half, Y on the lower half.
	// In X/Y mode the half that is not selected gets a zero care mask, so
	// neither its value nor its mask can influence the result.
	// X/Y accesses are always words, so their bit 0 is forced out.
	bcc_lane_sel #(
		.EXCL_ODD (1'b1)
	) u_addr_sel (
		.xy_en    (xy_bus_enable_select_reg),
		.x_or_y   (x_or_y_selector_reg),
		.int_bus  (INT_ADDR),
		.x_bus    (X_MEM_ADDR_BUS),
		.y_bus    (Y_MEM_ADDR_BUS),
		.ref_val  (chan_c_compare_addr),
		.mask_val (chan_c_addr_mask),
		.bus_o    (a_bus),
		.ref_o    (a_ref),
		.care_o   (a_care)
	);

	// Data lane: same steering, bit 0 of the X/Y data takes part too.
	// There is no data mask in this block, so every selected data bit counts.
	bcc_lane_sel #(
		.EXCL_ODD (1'b0)
	) u_data_sel (
		.xy_en    (xy_bus_enable_select_reg),
		.x_or_y   (x_or_y_selector_reg),
		.int_bus  (INT_DATA),
		.x_bus    (X_MEM_DATA_BUS),
		.y_bus    (Y_MEM_DATA_BUS),
		.ref_val  (chan_c_compare_data),
		.mask_val ({`BCC_WW{1'b0}}),
		.bus_o    (d_bus),
		.ref_o    (d_ref),
		.care_o   (d_care)
	);

	// Masked address equality.
	bcc_masked_cmp u_addr_cmp (
		.bus_i  (a_bus),
		.ref_i  (a_ref),
		.care_i (a_care),
		.match  (a_eq)
	);

	// Data equality.
	bcc_masked_cmp u_data_cmp (
		.bus_i  (d_bus),
		.ref_i  (d_ref),
		.care_i (d_care),
		.match  (d_eq)
	);

	// A condition is only worth anything inside a monitored bus cycle.
	assign a_hit = a_eq & CYCLE_VALID;
	assign d_hit = d_eq & CYCLE_VALID;

	// Sticky hits clear on a write of one; a hit in the same cycle wins.
	// The clear is honoured only through byte lane 0, where both flags live.
	// Software that clears while a matching cycle is in flight keeps the flag;
	// losing a hit would hide a break that really happened.
	always @* begin
		addr_hit_next = addr_hit_reg;
		data_hit_next = data_hit_reg;
		if (wr_go && sel[7] && BYTEENABLE[0]) begin
			if (WRITEDATA[`BCC_ST_AHIT])
				addr_hit_next = 1'b0;
			if (WRITEDATA[`BCC_ST_DHIT])
				data_hit_next = 1'b0;
		end
		if (a_hit)
			addr_hit_next = 1'b1;
		if (d_hit)
			data_hit_next = 1'b1;
	end

	// Match outputs are registered, one cycle after the sampled bus cycle.
	// The live bits of the status word follow these flops, so a read shows the
	// result of the cycle before the read was taken.
	always @(posedge MCLK) begin
		if (!RESET_N) begin
			ADDR_MATCH   <= 1'b0;
			DATA_MATCH   <= 1'b0;
			addr_hit_reg <= 1'b0;
			data_hit_reg <= 1'b0;
		end else begin
			ADDR_MATCH   <= a_hit;
			DATA_MATCH   <= d_hit;
			addr_hit_reg <= addr_hit_next;
			data_hit_reg <= data_hit_next;
		end
	end

endmodule // bcc_top

// >>> rtl/bcc_map.vh
// Register map, field positions and widths of the channel C match block.
`ifndef BCC_MAP_VH
`define BCC_MAP_VH

// Bus and half widths.
`define BCC_AW        5
`define BCC_DW        32
`define BCC_HW        16
`define BCC_WW        32

// Register byte offsets.
`define BCC_OFS_AH    5'h00
`define BCC_OFS_AL    5'h04
`define BCC_OFS_MH    5'h08
`define BCC_OFS_ML    5'h0C
`define BCC_OFS_DH    5'h10
`define BCC_OFS_DL    5'h14
`define BCC_OFS_SEL   5'h18
`define BCC_OFS_STAT  5'h1C

// Reset values.
`define BCC_RST_HALF  16'h0000
`define BCC_RST_BIT   1'b0
`define BCC_RST_WORD  32'h00000000

// Field positions in the select register.
`define BCC_SEL_XYEN  9
`define BCC_SEL_XSY   8

// Field positions in the status register.
`define BCC_ST_ALIVE  0
`define BCC_ST_DLIVE  1
`define BCC_ST_AHIT   2
`define BCC_ST_DHIT   3

// Bit of the X/Y address buses that never takes part.
`define BCC_XY_ODD    0

// Decode result width.
`define BCC_NREG      8

`endif

// >>> rtl/bcc_lane_sel.v
// Steers bus and care mask by the X/Y bus selection; the compare value passes through unchanged.
`timescale 1ns/1ps
`include "bcc_map.vh"

module bcc_lane_sel #(
	parameter EXCL_ODD = 1'b0
) (
	// Selection.
	input  wire                 xy_en,
	input  wire                 x_or_y,
	// Candidate buses.
	input  wire [`BCC_WW-1:0]   int_bus,
	input  wire [`BCC_HW-1:0]   x_bus,
	input  wire [`BCC_HW-1:0]   y_bus,
	// Programmed value and mask.
	input  wire [`BCC_WW-1:0]   ref_val,
	input  wire [`BCC_WW-1:0]   mask_val,
	// Steered result.
	output reg  [`BCC_WW-1:0]   bus_o,
	output reg  [`BCC_WW-1:0]   ref_o,
	output reg  [`BCC_WW-1:0]   care_o
);

	// A care bit is one for every bit that must match; a zero mask bit counts.
	always @* begin
		bus_o  = int_bus;
		ref_o  = ref_val;
		care_o = ~mask_val;
		if (xy_en) begin
			if (!x_or_y) begin
				// The X bus meets the upper half only.
				bus_o  = {x_bus, `BCC_RST_HALF};
				care_o = {~mask_val[`BCC_WW-1:`BCC_HW], `BCC_RST_HALF};
				if (EXCL_ODD)
					care_o[`BCC_HW+`BCC_XY_ODD] = 1'b0;
			end else begin
				// The Y bus meets the lower half only.
				bus_o  = {`BCC_RST_HALF, y_bus};
				care_o = {`BCC_RST_HALF, ~mask_val[`BCC_HW-1:0]};
				if (EXCL_ODD)
					care_o[`BCC_XY_ODD] = 1'b0;
			end
		end
	end

endmodule // bcc_lane_sel

// >>> rtl/bcc_masked_cmp.v
// Bitwise masked equality of a bus against a programmed value.
`timescale 1ns/1ps
`include "bcc_map.vh"

module bcc_masked_cmp (
	// Operands.
	input  wire [`BCC_WW-1:0]   bus_i,
	input  wire [`BCC_WW-1:0]   ref_i,
	input  wire [`BCC_WW-1:0]   care_i,
	// Result.
	output wire                 match
);

	wire [`BCC_WW-1:0] bit_ok;

	// Each bit passes when it is ignored or when it equals its reference.
	genvar i;
	generate
		for (i = 0; i < `BCC_WW; i = i + 1) begin : g_bit
			assign bit_ok[i] = ~care_i[i] | ~(bus_i[i] ^ ref_i[i]);
		end
	endgenerate

	// Every bit must pass.
	assign match = &bit_ok;

endmodule // bcc_masked_cmp

// >>> dv/bcc_top_assertions.sv
// Concurrent checks on the ports of the channel C match block.
`timescale 1ns/1ps
module bcc_chk (
	// Clock and reset.
	input wire        MCLK,
	input wire        RESET_N,
	// Register bus.
	input wire [4:0]  ADDRESS,
	input wire        READ,
	input wire        WRITE,
	input wire [31:0] READDATA,
	input wire        WAITREQUEST,
	// Match path.
	input wire        CYCLE_VALID,
	input wire        ADDR_MATCH,
	input wire        DATA_MATCH
);
	// One clock domain, so every check shares the clock and the reset.
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	a_idle_no_hit: assert property (!CYCLE_VALID |=> !ADDR_MATCH && !DATA_MATCH)
		else $error("Match raised without a monitored cycle.");
	a_reset_clear: assert property ($rose(RESET_N) |-> WAITREQUEST && !ADDR_MATCH && READDATA == 0)
		else $error("Outputs not cleared by reset.");
	a_one_wait: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
		else $error("Access not answered after one cycle.");
	a_wait_pulse: assert property (!WAITREQUEST |=> WAITREQUEST)
		else $error("Waitrequest low for more than one cycle.");
	a_no_req_wait: assert property (!READ && !WRITE |=> WAITREQUEST)
		else $error("Answer without a request.");
	a_upper_zero: assert property (READ && WAITREQUEST |=> READDATA[31:16] == 16'h0000)
		else $error("Upper read data not zero.");
	a_unmapped_zero: assert property (READ && WAITREQUEST && ADDRESS[1:0] != 2'h0 |=> READDATA == 0)
		else $error("Unmapped read returned data.");
	a_data_hold: assert property (!READ |=> $stable(READDATA))
		else $error("Read data changed without a read.");

	// Main scenarios.
	c_addr_hit: cover property (ADDR_MATCH);
	c_data_hit: cover property (DATA_MATCH);
	c_write_done: cover property (WRITE && !WAITREQUEST);
endmodule // bcc_chk

bind bcc_top bcc_chk i_bcc_chk (.MCLK, .RESET_N, .ADDRESS, .READ, .WRITE, .READDATA,
	.WAITREQUEST, .CYCLE_VALID, .ADDR_MATCH, .DATA_MATCH);

// >>> dv/bcc_bus_partner.sv
// Far-side model driving the internal and X/Y memory buses.
`timescale 1ns/1ps
module bcc_bus_partner (
	// Clock and requested bus cycle.
	input  wire        clk,
	input  wire        vld,
	input  wire [31:0] a,
	input  wire [31:0] d,
	// Buses towards the block.
	output wire        cyc,
	output wire [31:0] ia,
	output wire [31:0] id,
	output wire [15:0] xa,
	output wire [15:0] ya,
	output wire [15:0] xd,
	output wire [15:0] yd
);
	reg [31:0] la = 32'h00000000;
	reg [31:0] ld = 32'h00000000;
	// Between cycles the buses show the inverse of the last value, so a stale match cannot pass.
	assign cyc = vld;
	assign ia = vld ? a : ~la;
	assign id = vld ? d : ~ld;
	// X and Y buses carry the halves of the same word.
	assign xa = ia[31:16];
	assign ya = ia[15:0];
	assign xd = id[31:16];
	assign yd = id[15:0];
	// Remember the last driven cycle.
	always @(posedge clk) begin
		if (vld) begin
			la <= a;
			ld <= d;
		end
	end
endmodule // bcc_bus_partner

// >>> dv/testbench.sv
// Self-checking bench for the channel C match block.
`timescale 1ns/1ps
`include "bcc_map.vh"
module testbench;
	reg         mclk, reset_n, read, write, vld;
	reg  [4:0]  address;
	reg  [3:0]  byteenable;
	reg  [31:0] writedata, ba, bd, pa, pd, rd, r;
	wire [31:0] readdata, ia, id;
	wire [15:0] xa, ya, xd, yd;
	wire        waitrequest, cyc, addr_match, data_match;
	reg  [15:0] m [0:5];
	reg  [1:0]  sel, e, hit;
	integer     miscompares, n_compared, cycles, t, i;

	bcc_top i_bcc_top (.MCLK(mclk), .RESET_N(reset_n), .ADDRESS(address), .READ(read),
		.WRITE(write), .BYTEENABLE(byteenable), .WRITEDATA(writedata), .READDATA(readdata),
		.WAITREQUEST(waitrequest), .CYCLE_VALID(cyc), .INT_ADDR(ia), .INT_DATA(id),
		.X_MEM_ADDR_BUS(xa), .Y_MEM_ADDR_BUS(ya), .X_MEM_DATA_BUS(xd), .Y_MEM_DATA_BUS(yd),
		.ADDR_MATCH(addr_match), .DATA_MATCH(data_match));
	bcc_bus_partner i_bcc_bus_partner (.clk(mclk), .vld(vld), .a(ba), .d(bd), .cyc(cyc),
		.ia(ia), .id(id), .xa(xa), .ya(ya), .xd(xd), .yd(yd));

	// Free-running clock, 4 ns period.
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Verdict and end of run.
	task complete_run;
		if (miscompares == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// A hang counts as a mismatch.
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares = miscompares + 1;
			complete_run;
		end
	end

	task check(input [31:0] got, input [31:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low.
	task acc(input wr, input [4:0] a, input [31:0] wd, input [3:0] be);
		@(posedge mclk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= wd;
		byteenable <= be;
		// Only the cycle ceiling ends a wait that never comes.
		do begin
			@(posedge mclk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	// Reference register file: byte lanes 0 and 1 only, unmapped places ignored.
	task wreg(input [4:0] a, input [31:0] wd, input [3:0] be);
		acc(1'b1, a, wd, be);
		if (a[1:0] == 2'h0 && a[4:2] < 6) begin
			if (be[0]) m[a[4:2]][7:0] = wd[7:0];
			if (be[1]) m[a[4:2]][15:8] = wd[15:8];
		end else if (a == `BCC_OFS_SEL && be[1]) sel = wd[9:8];
		else if (a == `BCC_OFS_STAT && be[0]) hit = hit & ~wd[3:2];
	endtask

	// Reads every mapped half and one unmapped place.
	task readall;
		integer j;
		for (j = 0; j < 6; j = j + 1) begin
			acc(1'b0, 5'(j * 4), 32'h0, 4'hF);
			check(rd, {16'h0000, m[j]});
		end
		acc(1'b0, `BCC_OFS_SEL, 32'h0, 4'hF);
		check(rd, {22'h0, sel, 8'h00});
		acc(1'b0, `BCC_OFS_STAT, 32'h0, 4'hF);
		check(rd, {28'h0, hit, 2'b00});
		acc(1'b0, 5'h02, 32'h0, 4'hF);
		check(rd, 32'h0);
	endtask

	task do_reset;
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		for (i = 0; i < 6; i = i + 1) m[i] = 16'h0000;
		sel = 2'b00;
		hit = 2'b00;
	endtask

	// Expected address and data conditions for one monitored cycle.
	function [1:0] mexp(input [31:0] a, input [31:0] d);
		if (!sel[1]) mexp = {((a ^ {m[0], m[1]}) & ~{m[2], m[3]}) == 0, d == {m[4], m[5]}};
		else if (!sel[0]) mexp = {((a[31:16] ^ m[0]) & ~m[2] & 16'hFFFE) == 0, d[31:16] == m[4]};
		else mexp = {((a[15:0] ^ m[1]) & ~m[3] & 16'hFFFE) == 0, d[15:0] == m[5]};
	endfunction

	initial begin
		{miscompares, n_compared, cycles} = 0;
		{reset_n, read, write, vld, address, byteenable, writedata, ba, bd} = 0;
		r = $urandom(82);
		do_reset;
		wreg(5'h02, 32'hFFFFFFFF, 4'hF);
		readall;
		for (t = 0; t < 90; t = t + 1) begin
			if (t % 10 == 0) begin
				// New compare values, sparse masks, partial lanes now and then, cycling modes.
				for (i = 0; i < 6; i = i + 1) begin
					r = (i == 2 || i == 3) ? ($urandom & $urandom & $urandom) : $urandom;
					wreg(5'(i * 4), r, (t % 20 == 0) ? 4'($urandom) : 4'hF);
				end
				r = $urandom;
				r[9:8] = (t % 30 == 0) ? 2'b00 : (t % 30 == 10) ? 2'b10 : 2'b11;
				wreg(`BCC_OFS_SEL, r, 4'h2);
				readall;
				// Random clear of the sticky hits through lane 0.
				wreg(`BCC_OFS_STAT, $urandom, 4'h1);
			end
			r = $urandom;
			pa = {m[0], m[1]};
			pd = {m[4], m[5]};
			case (r[1:0])
				2'd0: pa = pa ^ ($urandom & {m[2], m[3]}) ^ {31'h0, r[2]};
				2'd1: pa = pa ^ (32'h1 << r[8:4]);
				2'd2: pa = $urandom;
				default: ;
			endcase
			if (r[3]) pd = pd ^ (32'h1 << r[13:9]);
			e = mexp(pa, pd) & {2{r[14] | r[15]}};
			hit = hit | e;
			@(posedge mclk);
			ba <= pa;
			bd <= pd;
			vld <= r[14] | r[15];
			@(posedge mclk);
			vld <= 1'b0;
			#1 check({30'h0, addr_match, data_match}, {30'h0, e});
		end
		do_reset;
		readall;
		complete_run;
	end
endmodule // testbench
